//--- hdl/cgpir_gain_ram.sv
// Indirect memory map, gain profile RAM and ramp counter of one transmit channel
`timescale 1ns/100ps
`default_nettype none
module cgpir_gain_ram import cgpir_pkg::*; #(
  parameter int GAIN_DEPTH = 128,
  parameter int COEF_DEPTH = 256,
  parameter int TXEN_DEPTH = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire cgpir_hostReq_s hostReq,
  input wire logic txEnablePin,
  input wire logic sampleStep,
  input wire logic [DATA_W-1:0] chanGain,
  output logic [DATA_W-1:0] rdData,
  output logic [DATA_W-1:0] gainOut,
  output logic [GAIN_W-1:0] profileWord,
  output logic hostHold
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (GAIN_DEPTH != 128 || COEF_DEPTH != 256 || TXEN_DEPTH != 8) begin : gBadParam
    $error("cgpir_gain_ram: depths must be 128, 256 and 8");
  end

  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  logic [GAIN_W-1:0] gainRam [GAIN_DEPTH];
  logic [DATA_W-1:0] coefI [COEF_DEPTH];
  logic [DATA_W-1:0] coefQ [COEF_DEPTH];
  logic [DATA_W-1:0] txenCycle [TXEN_DEPTH];
  logic [DATA_W-1:0] dataPort_reg;
  logic [DATA_W-1:0] dataPrev_reg;
  logic [DATA_W-1:0] indAddr_reg;
  logic [DATA_W-1:0] indRead_reg;
  logic [DATA_W-1:0] mainCtrl_reg;
  logic [DATA_W-1:0] gainCtrl_reg;
  logic [6:0] profLen_reg;
  logic [6:0] rampAddr_reg;
  logic [6:0] rampAddr_next;
  logic [GAIN_W-1:0] profWord_reg;
  logic [DATA_W-1:0] gainOut_reg;
  logic [DATA_W-1:0] rdData_reg;
  logic [DATA_W-1:0] rdData_next;
  logic [DATA_W-1:0] indWord;
  logic txSync1_reg;
  logic txSync2_reg;
  logic hold;
  logic indReq;
  logic indIsRead;
  logic [3:0] indPage;
  logic [7:0] indIdx;
  logic gainHit;
  logic txenHit;
  logic [27:0] product;

  assign hold = mainCtrl_reg[HOLD_BIT];
  assign indReq = hostReq.wr && hostReq.addr == OFF_IND_ADDR;
  assign indIsRead = hostReq.data[ACC_READ_BIT];
  assign indPage = hostReq.data[PAGE_MSB:PAGE_LSB];
  assign indIdx = hostReq.data[7:0];
  assign gainHit = indPage == PAGE_GAIN && !indIdx[7];
  assign txenHit = indPage == PAGE_TXEN && indIdx[7:3] == 5'h00;

  // ----------------------------------------
  // Direct registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mainCtrl_reg <= RESET_WORD;
      gainCtrl_reg <= RESET_WORD;
      profLen_reg <= 7'h00;
      dataPort_reg <= RESET_WORD;
      dataPrev_reg <= RESET_WORD;
      indAddr_reg <= RESET_WORD;
    end else if (hostReq.wr) begin
      case (hostReq.addr)
        OFF_MAIN_CTRL: mainCtrl_reg <= hostReq.data;
        OFF_GAIN_CTRL: gainCtrl_reg <= hostReq.data;
        OFF_PROF_LEN: profLen_reg <= hostReq.data[6:0];
        OFF_IND_DATA: begin
          dataPort_reg <= hostReq.data;
          dataPrev_reg <= dataPort_reg;
        end
        OFF_IND_ADDR: indAddr_reg <= hostReq.data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Indirect writes
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (indReq && !indIsRead) begin
      case (indPage)
        PAGE_GAIN: if (gainHit) gainRam[indIdx[6:0]] <= dataPort_reg[GAIN_W-1:0];
        PAGE_COEF_IQ: begin
          coefI[indIdx] <= dataPort_reg;
          coefQ[indIdx] <= dataPrev_reg;
        end
        PAGE_COEF_SAME: begin
          coefI[indIdx] <= dataPort_reg;
          coefQ[indIdx] <= dataPort_reg;
        end
        PAGE_TXEN: if (txenHit) txenCycle[indIdx[2:0]] <= dataPort_reg;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Indirect and direct reads
  // ----------------------------------------
  always_comb begin
    case (indPage)
      PAGE_GAIN: indWord = gainHit ? {4'h0, gainRam[indIdx[6:0]]} : RESET_WORD;
      PAGE_COEF_IQ: indWord = coefI[indIdx];
      PAGE_COEF_SAME: indWord = coefQ[indIdx];
      PAGE_TXEN: indWord = txenHit ? txenCycle[indIdx[2:0]] : RESET_WORD;
      default: indWord = RESET_WORD;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      indRead_reg <= RESET_WORD;
    end else if (indReq && indIsRead) begin
      indRead_reg <= indWord;
    end
  end

  always_comb begin
    case (hostReq.addr)
      OFF_PROF_LEN: rdData_next = {9'h000, profLen_reg};
      OFF_MAIN_CTRL: rdData_next = mainCtrl_reg;
      OFF_GAIN_CTRL: rdData_next = gainCtrl_reg;
      OFF_IND_DATA: rdData_next = indRead_reg;
      OFF_IND_ADDR: rdData_next = indAddr_reg;
      default: rdData_next = RESET_WORD;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdData_reg <= RESET_WORD;
    end else if (indReq && indIsRead) begin
      rdData_reg <= indWord;
    end else if (hostReq.rd) begin
      rdData_reg <= rdData_next;
    end
  end

  // ----------------------------------------
  // Transmit enable synchroniser
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      txSync1_reg <= 1'b0;
      txSync2_reg <= 1'b0;
    end else begin
      txSync1_reg <= txEnablePin;
      txSync2_reg <= txSync1_reg;
    end
  end

  // ----------------------------------------
  // Ramp address counter
  // ----------------------------------------
  always_comb begin
    rampAddr_next = rampAddr_reg;
    if (!txSync2_reg) begin
      rampAddr_next = 7'h00;
    end else if (sampleStep && !hold && rampAddr_reg < profLen_reg) begin
      rampAddr_next = rampAddr_reg + 7'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rampAddr_reg <= 7'h00;
    end else begin
      rampAddr_reg <= rampAddr_next;
    end
  end

  // ----------------------------------------
  // Profile word and gain multiply
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      profWord_reg <= GAIN_UNITY;
    end else if (!hold) begin
      profWord_reg <= gainRam[rampAddr_reg];
    end
  end

  assign product = chanGain * profWord_reg;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      gainOut_reg <= RESET_WORD;
    end else if (!gainCtrl_reg[PROF_EN_BIT]) begin
      gainOut_reg <= chanGain;
    end else if (product[27]) begin
      gainOut_reg <= 16'hFFFF;
    end else begin
      gainOut_reg <= product[26:FRAC_BITS];
    end
  end

  assign rdData = rdData_reg;
  assign gainOut = gainOut_reg;
  assign profileWord = profWord_reg;
  assign hostHold = mainCtrl_reg[HOLD_BIT];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence sWriteReq(logic [3:0] pg);
    indReq && !indIsRead && indPage == pg;
  endsequence

  sequence sIgnoredWrite;
    indReq && !indIsRead && !gainHit && !txenHit && indPage != PAGE_COEF_IQ && indPage != PAGE_COEF_SAME;
  endsequence

  sequence sStepOpen;
    txSync2_reg && sampleStep && !hold;
  endsequence

  rampStep_a: assert property (@(posedge clock) disable iff (!nrst)
    sStepOpen and (rampAddr_reg < profLen_reg) |=> rampAddr_reg == $past(rampAddr_reg) + 7'h01)
    else $error("ramp address did not advance");

  rampStop_a: assert property (@(posedge clock) disable iff (!nrst)
    txSync2_reg && rampAddr_reg >= profLen_reg |=> rampAddr_reg == $past(rampAddr_reg))
    else $error("ramp address moved past length");

  rampClear_a: assert property (@(posedge clock) disable iff (!nrst)
    !txSync2_reg |=> rampAddr_reg == 7'h00)
    else $error("ramp address not cleared");

  gainWrite_a: assert property (@(posedge clock) disable iff (!nrst)
    sWriteReq(PAGE_GAIN) and gainHit |=> gainRam[$past(indIdx[6:0])] == $past(dataPort_reg[GAIN_W-1:0]))
    else $error("gain word not written");

  pairWrite_a: assert property (@(posedge clock) disable iff (!nrst)
    sWriteReq(PAGE_COEF_IQ) |=> coefI[$past(indIdx)] == $past(dataPort_reg)
      && coefQ[$past(indIdx)] == $past(dataPrev_reg))
    else $error("I and Q pair not written");

  sameWrite_a: assert property (@(posedge clock) disable iff (!nrst)
    sWriteReq(PAGE_COEF_SAME) |=> coefI[$past(indIdx)] == coefQ[$past(indIdx)])
    else $error("shared coefficient differs");

  readBack_a: assert property (@(posedge clock) disable iff (!nrst)
    indReq && indIsRead |=> rdData_reg == $past(indWord) && indRead_reg == $past(indWord))
    else $error("read word not on bus");

  unusedPage_a: assert property (@(posedge clock) disable iff (!nrst)
    sIgnoredWrite |=> gainRam[$past(indIdx[6:0])] == $past(gainRam[indIdx[6:0]]))
    else $error("unused page changed a RAM");

  holdFreeze_a: assert property (@(posedge clock) disable iff (!nrst)
    hold ##1 hold |-> $stable(profWord_reg) && $stable(rampAddr_reg))
    else $error("ramp moved under hold");

  gainBypass_a: assert property (@(posedge clock) disable iff (!nrst)
    !gainCtrl_reg[PROF_EN_BIT] |=> gainOut_reg == $past(chanGain))
    else $error("gain applied while profile off");
endmodule // cgpir_gain_ram
`default_nettype wire

//--- inc/cgpir_pkg.sv
// Constants, register map and carrier types of the channel gain profile block
// Notes on behaviour
// - Page 0 is gain RAM, page 4 transmit timing values, pages 2 and 5-F unused.
// - Page 1 reads return I coefficients; writes load separate I and Q values.
// - Page 3 reads return Q coefficients; a write loads one value for both.
// - Gain RAM has 128 words, 12-bit value low, upper four bits read zero.
// - Channel gain is multiplied by the profile word only when 0x0d bit 15 set.
// - Ramp read address steps by one per step while transmit enable is active and 0x0c bit 14 (hold) is clear.
// - Ramp address stops at the profile length in 0x0b and never wraps.
// - Address port write with bit 15 clear copies the data port into the RAM.
// - A read request drives the selected RAM word onto the read bus.
// - Address port bit 15 selects access type: one read, zero write.
// - A 16-bit indirect data port sits at direct address 0x14.
package cgpir_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int GAIN_W = 12;
  localparam int FRAC_BITS = 11;
  localparam logic [ADDR_W-1:0] OFF_PROF_LEN = 8'h0B;
  localparam logic [ADDR_W-1:0] OFF_MAIN_CTRL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_GAIN_CTRL = 8'h0D;
  localparam logic [ADDR_W-1:0] OFF_IND_DATA = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_IND_ADDR = 8'h15;
  localparam int HOLD_BIT = 14;
  localparam int PROF_EN_BIT = 15;
  localparam int ACC_READ_BIT = 15;
  localparam int PAGE_LSB = 8;
  localparam int PAGE_MSB = 11;
  localparam logic [3:0] PAGE_GAIN = 4'h0;
  localparam logic [3:0] PAGE_COEF_IQ = 4'h1;
  localparam logic [3:0] PAGE_COEF_SAME = 4'h3;
  localparam logic [3:0] PAGE_TXEN = 4'h4;
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 12'h800;
  localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;
  localparam int ACCESS_GAP = 4;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cgpir_hostReq_s;
endpackage

//--- bench/cgpir_host_model.sv
// Host processor model driving the parallel register port
`timescale 1ns/100ps
`default_nettype none
module cgpir_host_model import cgpir_pkg::*; (
  input wire logic clock,
  output var cgpir_hostReq_s hostReq
);
  initial begin
    hostReq = '0;
  end
  task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic rd);
    @(negedge clock);
    hostReq.wr = !rd;
    hostReq.rd = rd;
    hostReq.addr = a;
    hostReq.data = d;
    @(negedge clock);
    hostReq.wr = 1'b0;
    hostReq.rd = 1'b0;
    hostReq.addr = ~a;
    hostReq.data = ~d;
  endtask
  task automatic ramWr(input logic [11:0] idx, input logic [DATA_W-1:0] d);
    put(OFF_IND_DATA, d, 1'b0);
    put(OFF_IND_ADDR, {4'h0, idx}, 1'b0);
    repeat (ACCESS_GAP) @(negedge clock);
  endtask
  task automatic ramRd(input logic [11:0] idx);
    put(OFF_IND_ADDR, {4'h8, idx}, 1'b0);
    repeat (ACCESS_GAP) @(negedge clock);
  endtask
  task automatic hold(input logic on);
    put(OFF_MAIN_CTRL, on ? 16'h4000 : 16'h0000, 1'b0);
  endtask
endmodule // cgpir_host_model
`default_nettype wire

//--- bench/channel_gain_profile_indirect_ram_test.sv
// Testbench of the gain profile block
`timescale 1ns/100ps
`default_nettype none
module channel_gain_profile_indirect_ram_test import cgpir_pkg::*;;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic txEnablePin = 1'b0;
  logic sampleStep = 1'b0;
  logic [15:0] chanGain = 16'h1000;
  cgpir_hostReq_s hostReq;
  logic [15:0] rdData;
  logic [15:0] gainOut;
  logic [11:0] profileWord;
  logic hostHold;
  logic [11:0] g [4] = '{12'h400, 12'h600, 12'h700, 12'h800};
  logic [3:0] pg [3] = '{4'h2, 4'h5, 4'hF};
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  // ----------------------------------------
  // Clock, timeout, instances
  // ----------------------------------------
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      finish_test();
    end
  end
  cgpir_host_model host (.clock(clock), .hostReq(hostReq));
  cgpir_gain_ram dut (.clock(clock), .nrst(nrst), .hostReq(hostReq), .txEnablePin(txEnablePin),
    .sampleStep(sampleStep), .chanGain(chanGain), .rdData(rdData), .gainOut(gainOut),
    .profileWord(profileWord), .hostHold(hostHold));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked = checked + 1;
    if (s !== e) begin
      failures = failures + 1;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdBack(input logic [11:0] idx, input logic [15:0] e);
    host.ramRd(idx);
    chk("rdData", e, rdData);
  endtask
  task automatic step();
    @(negedge clock);
    sampleStep = 1'b1;
    @(negedge clock);
    sampleStep = 1'b0;
    repeat (4) @(negedge clock);
  endtask
  task automatic finish_test();
    if (failures == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    chk("rdData", 16'h0000, rdData);
    chk("profileWord", 16'h0800, {4'h0, profileWord});
    host.hold(1'b1);
    chk("hostHold", 16'h0001, {15'h0000, hostHold});
    for (int i = 0; i < 4; i++) host.ramWr(i[11:0], {4'hF, g[i]});
    host.ramWr(12'h07F, 16'hFABC);
    rdBack(12'h07F, 16'h0ABC);
    host.ramWr(12'h080, 16'h0123);
    rdBack(12'h080, 16'h0000);
    for (int i = 0; i < 4; i++) rdBack(i[11:0], {4'h0, g[i]});
    host.put(OFF_IND_DATA, 16'h0000, 1'b1);
    @(negedge clock);
    chk("dataPort", 16'h0800, rdData);
    for (int i = 0; i < 3; i++) begin
      host.ramWr({pg[i], 8'h00}, 16'h5A5A);
      rdBack(12'h000, 16'h0400);
      rdBack({pg[i], 8'h00}, 16'h0000);
    end
    host.put(OFF_IND_DATA, 16'h1111, 1'b0);
    host.ramWr(12'h105, 16'h2222);
    rdBack(12'h105, 16'h2222);
    rdBack(12'h305, 16'h1111);
    host.ramWr(12'h306, 16'h3333);
    rdBack(12'h106, 16'h3333);
    rdBack(12'h306, 16'h3333);
    host.ramWr(12'h402, 16'h4444);
    rdBack(12'h402, 16'h4444);
    host.put(OFF_PROF_LEN, 16'h0003, 1'b0);
    host.put(OFF_PROF_LEN, 16'h0000, 1'b1);
    @(negedge clock);
    chk("profLen", 16'h0003, rdData);
    host.put(OFF_GAIN_CTRL, 16'h8000, 1'b0);
    host.hold(1'b0);
    chk("hostHold", 16'h0000, {15'h0000, hostHold});
    txEnablePin = 1'b1;
    repeat (8) @(negedge clock);
    chk("profileWord", 16'h0400, {4'h0, profileWord});
    chk("gainOut", 16'h0800, gainOut);
    step();
    chk("profileWord", 16'h0600, {4'h0, profileWord});
    chk("gainOut", 16'h0C00, gainOut);
    repeat (5) step();
    chk("profileWord", 16'h0800, {4'h0, profileWord});
    chk("gainOut", 16'h1000, gainOut);
    chanGain = 16'h1234;
    txEnablePin = 1'b0;
    repeat (8) @(negedge clock);
    chk("profileWord", 16'h0400, {4'h0, profileWord});
    chk("gainOut", 16'h091A, gainOut);
    host.put(OFF_GAIN_CTRL, 16'h0000, 1'b0);
    repeat (4) @(negedge clock);
    chk("gainOut", 16'h1234, gainOut);
    host.hold(1'b1);
    txEnablePin = 1'b1;
    repeat (8) @(negedge clock);
    step();
    chk("profileWord", 16'h0400, {4'h0, profileWord});
    finish_test();
  end
endmodule // channel_gain_profile_indirect_ram_test
`default_nettype wire
